// ### src/cbc_camera_back_control.sv
// module: camera back identification, inquiry reply and shutter/advance control
//
// What this block does
// [RULE1] An inquiry returns one type-code byte followed by the text naming the fitted back.
// [RULE2] Type codes are 80h pack film, 81h 35mm, 82h auto film and 83h 4 x 5.
// [RULE3] With no back fitted the inquiry reports the pack-film code and text.
// [RULE4] The back presents its type on four sense lines, which are decoded through a selector.
// [RULE5] At exposure start the shutter/advance drive is asserted, opening the shutter.
// [RULE6] When the exposure completes the drive is released, closing the shutter.
// [RULE7] An exposure whose film parameter does not suit the fitted back is refused.
// [RULE8] On shutter close a motorized back winds on by itself; others eject the frame.
module cbc_camera_back_control
  import cbc_pkg::*;
(
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // camera back pins
  input  wire logic [3:0]     camera_back_type_lines,
  output logic                shutter_advance_drive,
  // inquiry request and reply stream
  input  wire logic           inquire,
  input  wire logic           reply_ready,
  output cbc_reply_type       reply,
  // exposure control
  input  wire cbc_expose_type expose,
  input  wire logic           expose_done,
  output logic                expose_busy,
  output logic                expose_refused
);

  // reply sequencer states
  typedef enum logic [1:0] {
    cbc_idle,
    cbc_code,
    cbc_text
  } cbc_reply_state_type;

  // sense pattern of each back, indexed by film code
  localparam logic [3:0] SENSE_TABLE [4] = '{
    SENSE_PACK_FILM,
    SENSE_35MM,
    SENSE_AUTO_FILM,
    SENSE_4X5
  };

  cbc_reply_state_type   state;
  cbc_reply_state_type   next_state;
  logic [3:0]            sense_match;
  cbc_film_type          fitted;
  cbc_film_type          held_back;
  logic [7:0]            type_code;
  logic [8*TEXT_LEN-1:0] text;
  logic [3:0]            text_index;
  logic [7:0]            next_byte;
  logic                  inquiry_take;
  logic                  reply_accept;
  logic                  reply_final;
  logic                  expose_take;
  logic                  film_match;

  // one comparator per back on the sense lines
  for (genvar b = 0; b < 4; b++) begin : g_sense
    assign sense_match[b] = (camera_back_type_lines == SENSE_TABLE[b]); // RULE4
  end

  // selector: unknown or absent pattern reads as pack film
  always_comb begin
    if (sense_match[1]) begin
      fitted = cbc_film_35mm; // RULE4
    end else if (sense_match[2]) begin
      fitted = cbc_film_auto;
    end else if (sense_match[3]) begin
      fitted = cbc_film_4x5;
    end else begin
      fitted = cbc_film_pack; // RULE3
    end
  end

  // back frozen at inquiry so code and text describe one back
  always_ff @(posedge clock) begin
    if (rst) begin
      held_back <= cbc_film_pack;
    end else if (inquiry_take) begin
      held_back <= fitted;
    end
  end

  // type code of the back seen at the inquiry edge
  always_comb begin
    case (fitted)
      cbc_film_35mm: begin
        type_code = TYPE_35MM; // RULE2
      end
      cbc_film_auto: begin
        type_code = TYPE_AUTO_FILM; // RULE2
      end
      cbc_film_4x5: begin
        type_code = TYPE_4X5; // RULE2
      end
      cbc_film_pack: begin
        type_code = TYPE_PACK_FILM; // RULE2
      end
      default: begin
        type_code = TYPE_PACK_FILM; // RULE3
      end
    endcase
  end

  // description text of the frozen back, space padded
  always_comb begin
    case (held_back)
      cbc_film_35mm: begin
        text = "35mm     ";
      end
      cbc_film_auto: begin
        text = "Auto Film";
      end
      cbc_film_4x5: begin
        text = "4 x 5    ";
      end
      cbc_film_pack: begin
        text = "Pack Film";
      end
      default: begin
        text = "Pack Film";
      end
    endcase
  end

  // text byte selected by index, first character first
  always_comb begin
    next_byte = 8'h00;
    for (int i = 0; i < TEXT_LEN; i++) begin
      if (text_index == 4'(i)) begin
        next_byte = text[8*(TEXT_LEN-1-i) +: 8];
      end
    end
  end

  // handshake qualifiers
  assign inquiry_take = (state == cbc_idle) && inquire;
  assign reply_accept = reply.valid && reply_ready;
  assign reply_final  = reply_accept && reply.last;
  assign expose_take  = expose.start && !expose_busy;
  assign film_match   = (expose.film == fitted);

  // reply sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      cbc_idle: begin
        if (inquiry_take) begin
          next_state = cbc_code;
        end
      end
      cbc_code: begin
        if (reply_accept) begin
          next_state = cbc_text;
        end
      end
      cbc_text: begin
        if (reply_final) begin
          next_state = cbc_idle;
        end
      end
      default: begin
        next_state = cbc_idle;
      end
    endcase
  end

  // reply sequencer state
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= cbc_idle;
    end else begin
      state <= next_state;
    end
  end

  // text position
  always_ff @(posedge clock) begin
    if (rst) begin
      text_index <= 4'h0;
    end else if (inquiry_take) begin
      text_index <= 4'h0;
    end else if (reply_accept && !reply.last) begin
      text_index <= text_index + 4'h1;
    end
  end

  // reply byte stream: code first, then text, last flag on final text byte
  always_ff @(posedge clock) begin
    if (rst) begin
      reply <= '0;
    end else if (inquiry_take) begin
      reply.valid <= 1'b1; // RULE1
      reply.last  <= 1'b0;
      reply.data  <= type_code; // RULE2
    end else if (reply_final) begin
      reply <= '0;
    end else if (reply_accept) begin
      reply.valid <= 1'b1; // RULE1
      reply.last  <= (text_index == TEXT_LAST);
      reply.data  <= next_byte;
    end
  end

  // drive: open on an accepted start, release when the host ends the exposure
  always_ff @(posedge clock) begin
    if (rst) begin
      shutter_advance_drive <= RESET_DRIVE;
    end else if (expose_busy && expose_done) begin
      shutter_advance_drive <= 1'b0; // RULE6 RULE8
    end else if (expose_take && film_match) begin
      shutter_advance_drive <= 1'b1; // RULE5
    end
  end

  // busy follows the drive
  always_ff @(posedge clock) begin
    if (rst) begin
      expose_busy <= 1'b0;
    end else if (expose_busy && expose_done) begin
      expose_busy <= 1'b0; // RULE6
    end else if (expose_take && film_match) begin
      expose_busy <= 1'b1; // RULE5
    end
  end

  // one-cycle refusal on film mismatch
  always_ff @(posedge clock) begin
    if (rst) begin
      expose_refused <= 1'b0;
    end else begin
      expose_refused <= expose_take && !film_match; // RULE7
    end
  end

endmodule

// ### src/cbc_pkg.sv
// package: constants and types for the camera back control block
package cbc_pkg;

  // type codes returned on camera inquiry
  localparam logic [7:0] TYPE_PACK_FILM = 8'h80;
  localparam logic [7:0] TYPE_35MM      = 8'h81;
  localparam logic [7:0] TYPE_AUTO_FILM = 8'h82;
  localparam logic [7:0] TYPE_4X5       = 8'h83;

  // sense-line patterns presented by each back (one-hot, all zero = none fitted)
  localparam logic [3:0] SENSE_NONE      = 4'h0;
  localparam logic [3:0] SENSE_PACK_FILM = 4'h1;
  localparam logic [3:0] SENSE_35MM      = 4'h2;
  localparam logic [3:0] SENSE_AUTO_FILM = 4'h4;
  localparam logic [3:0] SENSE_4X5       = 4'h8;

  // text length of each description, padded with spaces
  localparam int unsigned TEXT_LEN = 9;
  localparam logic [3:0] TEXT_LAST = 4'h8;

  // reset values
  localparam logic RESET_DRIVE = 1'b0;

  // film parameter codes carried by the expose command
  typedef enum logic [1:0] {
    cbc_film_pack,
    cbc_film_35mm,
    cbc_film_auto,
    cbc_film_4x5
  } cbc_film_type;

  // expose request from the host command path
  typedef struct packed {
    logic         start;
    cbc_film_type film;
  } cbc_expose_type;

  // byte stream toward the host
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } cbc_reply_type;

endpackage

// ### verification/cbc_back_model.sv
// camera back model: presents the sense pattern of the fitted back
module cbc_back_model
  import cbc_pkg::*;
(
  input  logic       clock,
  input  logic [3:0] fitted,
  input  logic       shutter_advance_drive,
  output logic [3:0] camera_back_type_lines,
  output logic [7:0] frames_advanced,
  output logic [7:0] frames_ejected
);
  timeunit 1ns / 1ns;
  logic drive_seen = 1'b0;
  assign camera_back_type_lines = fitted;
  initial begin
    frames_advanced = 8'h00;
    frames_ejected  = 8'h00;
  end
  // shutter close: motorized backs wind on, others eject
  always @(posedge clock) begin
    drive_seen <= shutter_advance_drive;
    if (drive_seen && !shutter_advance_drive) begin
      if (fitted == SENSE_35MM || fitted == SENSE_AUTO_FILM) begin
        frames_advanced <= frames_advanced + 8'h01;
      end else begin
        frames_ejected <= frames_ejected + 8'h01;
      end
    end
  end
endmodule

// ### verification/cbc_monitor.sv
// checker: assertions on the camera back control ports
module cbc_monitor
  import cbc_pkg::*;
(
  input logic           clock, rst, inquire, reply_ready, expose_done,
  input logic           shutter_advance_drive, expose_busy, expose_refused,
  input logic [3:0]     camera_back_type_lines,
  input cbc_reply_type  reply,
  input cbc_expose_type expose
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire [3:0] s = camera_back_type_lines;
  wire [1:0] ix = s == 4'h2 ? 2'h1 : s == 4'h4 ? 2'h2 : s == 4'h8 ? 2'h3 : 2'h0;
  wire       ask = inquire && !reply.valid;
  wire       take = expose.start && !expose_busy;
  sequence s_inquiry;
    ask ##1 reply_ready [*8] ##1 reply_ready;
  endsequence
  a_type_code: assert property (ask |=> reply.data == {6'h20, ix})
    else $error("code");
  a_text_length: assert property (s_inquiry |-> !reply.last ##1 reply.last)
    else $error("length");
  a_shutter_open: assert property (take && expose.film == ix |=> shutter_advance_drive)
    else $error("open");
  a_film_refused: assert property (take && expose.film != ix |=> expose_refused)
    else $error("refuse");
  a_shutter_close: assert property (expose_busy && expose_done |=> !shutter_advance_drive)
    else $error("close");
  a_reply_done: assert property (reply.valid && reply.last && reply_ready |=> !reply.valid)
    else $error("done");
  a_drive_busy: assert property (shutter_advance_drive == expose_busy)
    else $error("busy");
endmodule
bind cbc_camera_back_control cbc_monitor cbc_monitor_i (.*);

// ### verification/test_camera_back_control.sv
// testbench: inquiry replies and exposure control
module test_camera_back_control
  import cbc_pkg::*;
();
  timeunit 1ns / 1ns;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s %h %h", n, e, s); end end
  logic clock = 0, rst = 1, inquire = 0, reply_ready = 0, expose_done = 0;
  logic shutter_advance_drive, expose_busy, expose_refused;
  logic [3:0] fitted = 0, camera_back_type_lines;
  logic [7:0] frames_advanced, frames_ejected;
  cbc_reply_type reply;
  cbc_expose_type expose = '0;
  wire [9:0] rp = {reply.valid, reply.last, reply.data};
  wire [2:0] ex_out = {shutter_advance_drive, expose_refused, expose_busy};
  int error_cnt = 0, cmp_count = 0;
  always #5 clock = ~clock;
  cbc_back_model cbc_back_model_i (.*);
  cbc_camera_back_control cbc_camera_back_control_i (.*);
  task automatic report_and_stop;
    $display("errors %0d of %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic inq(input logic [3:0] s, input logic [7:0] c, input logic [71:0] t);
    fitted <= s;
    inquire <= 1;
    @(posedge clock) inquire <= 0;
    reply_ready <= 1;
    #1 `CHK("code", {2'b10, c}, rp)
    for (int k = 0; k < 9; k++) begin
      @(posedge clock) #1 `CHK("text", {1'b1, k == 8, t[8*(8-k) +: 8]}, rp)
    end
    @(posedge clock) reply_ready <= 0;
    #1 `CHK("idle", 1'b0, reply.valid)
    @(posedge clock);
  endtask
  task automatic expo(input logic [3:0] s, input logic [1:0] f, input logic [1:0] e,
                      input logic [15:0] fr);
    fitted <= s;
    expose <= {1'b1, f};
    @(posedge clock) expose <= '0;
    expose_done <= 1;
    #1 `CHK("expose", {e, e[1]}, ex_out)
    @(posedge clock) expose_done <= 0;
    #1 `CHK("close", 3'h0, ex_out)
    @(posedge clock) #1 `CHK("frames", fr, {frames_advanced, frames_ejected})
    @(posedge clock);
  endtask
  task automatic reset_busy;
    fitted <= SENSE_35MM;
    expose <= {1'b1, 2'h1};
    @(posedge clock) expose <= '0;
    rst <= 1;
    #1 `CHK("busy", 3'h5, ex_out)
    @(posedge clock) rst <= 0;
    #1 `CHK("reset", 3'h0, ex_out)
    @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    inq(SENSE_NONE, 8'h80, "Pack Film");
    inq(4'h3, 8'h80, "Pack Film");
    inq(SENSE_PACK_FILM, 8'h80, "Pack Film");
    inq(SENSE_35MM, 8'h81, "35mm     ");
    inq(SENSE_AUTO_FILM, 8'h82, "Auto Film");
    inq(SENSE_4X5, 8'h83, "4 x 5    ");
    expo(SENSE_AUTO_FILM, 2'h2, 2'h2, 16'h0100);
    expo(SENSE_4X5, 2'h1, 2'h1, 16'h0100);
    expo(SENSE_PACK_FILM, 2'h0, 2'h2, 16'h0101);
    reset_busy;
    report_and_stop;
  end
endmodule
